// ### hw/dac_cal_ctrl.sv
/*
 Calibration engine, coefficient memory and gain trim registers of a dual
 current-output converter. Assumes register port inputs and the sample-clock
 tick are synchronous to I_CORE_CLK.
*/
`timescale 1ns/1ns
module dac_cal_ctrl
    import dac_cal_pkg::*;
#(
    parameter int NUM_COEF = COEF_COUNT,
    parameter int CW = COEF_WIDTH
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_CLK_EN,
    input wire logic I_DAC_CLK_TICK,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_I_CM_ENABLE,
    input wire logic I_Q_CM_ENABLE,
    output logic [7:0] O_REG_RDATA,
    output logic O_CAL_CLK,
    output logic O_I_CM_CONNECT,
    output logic O_Q_CM_CONNECT,
    output trim_t O_TRIM
);
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b10
    } cal_state_t;

    reg_req_t req;
    logic [7:0] regs_q [0:15];
    logic [7:0] regs_d [0:15];
    logic [7:0] ctrl_q, ctrl_d, mem_q, mem_d, caddr_q, caddr_d, rdata_q, rdata_d;
    logic [CW-1:0] coef_mem [0:1][0:NUM_COEF-1];
    logic [3:0] pre_q, pre_d;
    logic [6:0] div_q, div_d, div_last;
    logic cal_clk_q, cal_clk_d, cal_tick;
    cal_state_t st_q [0:1];
    cal_state_t st_d [0:1];
    logic [4:0] idx_q [0:1];
    logic [4:0] idx_d [0:1];
    logic [4:0] slot;
    logic slot_ok, coef_wr, start;

    assign req = '{wr: I_REG_WR, rd: I_REG_RD, addr: I_REG_ADDR, wdata: I_REG_WDATA};
    // Address 1 maps to slot 0; address 0 and beyond 32 are outside the memory
    assign slot = 5'(caddr_q - 8'h01);
    assign slot_ok = (caddr_q >= 8'(COEF_FIRST_ADDR)) && (caddr_q <= 8'(NUM_COEF));
    assign coef_wr = req.wr && req.addr == ADDR_COEF_DATA && mem_q[MEM_WR_EN_BIT] && slot_ok;
    assign start = mem_q[MEM_START_BIT];
    // code 7 would reach 4096 cycles; held at the 2048-cycle ceiling
    assign div_last = (ctrl_q[2:0] == 3'h7) ? 7'(CAL_MAX_DIV / (2 * CAL_PREDIV) - 1)
                                            : 7'((1 << ctrl_q[2:0]) - 1);

    always_comb begin
        pre_d = pre_q;
        div_d = div_q;
        cal_clk_d = cal_clk_q;
        cal_tick = 1'b0;
        if (!ctrl_q[CTRL_CLK_EN_BIT]) begin
            pre_d = 4'h0;
            div_d = 7'h00;
            cal_clk_d = 1'b0;
        end else if (I_DAC_CLK_TICK) begin
            pre_d = 4'(pre_q + 4'h1);
            if (pre_q == 4'(CAL_PREDIV - 1)) begin
                // Selector n divides by 2^(n+1), top code capped: 32 to 2048 sample clocks
                if (div_q >= div_last) begin
                    div_d = 7'h00;
                    cal_clk_d = ~cal_clk_q;
                    cal_tick = cal_clk_q;
                end else begin
                    div_d = 7'(div_q + 7'h01);
                end
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            pre_q <= 4'h0;
            div_q <= 7'h00;
            cal_clk_q <= 1'b0;
        end else if (I_CLK_EN) begin
            pre_q <= pre_d;
            div_q <= div_d;
            cal_clk_q <= cal_clk_d;
        end
    end

    // Register file
    always_comb begin
        for (int r = 0; r < 16; r++) begin
            regs_d[r] = regs_q[r];
        end
        ctrl_d = ctrl_q;
        mem_d = mem_q;
        caddr_d = caddr_q;
        rdata_d = rdata_q;
        if (req.wr) begin
            unique case (req.addr)
                ADDR_CAL_CTRL: ctrl_d = req.wdata;
                ADDR_COEF_ADDR: caddr_d = req.wdata;
                ADDR_CAL_MEM_CTRL: mem_d = req.wdata;
                default: begin
                    if (req.addr < 8'h10) begin
                        regs_d[req.addr[3:0]] = req.wdata;
                    end
                end
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CAL_CTRL: rdata_d = ctrl_q;
                ADDR_CAL_STATUS: rdata_d = {st_q[1] == CAL_DONE, st_q[0] == CAL_DONE, 6'h00};
                ADDR_COEF_ADDR: rdata_d = caddr_q;
                // coefficient readback, I core takes priority
                ADDR_COEF_DATA: begin
                    rdata_d = 8'h00;
                    if (mem_q[MEM_RD_EN_BIT] && slot_ok) begin
                        if (ctrl_q[CTRL_SEL_I_BIT]) begin
                            rdata_d = 8'(coef_mem[0][slot]);
                        end else if (ctrl_q[CTRL_SEL_Q_BIT]) begin
                            rdata_d = 8'(coef_mem[1][slot]);
                        end
                    end
                end
                ADDR_CAL_MEM_CTRL: rdata_d = mem_q;
                default: rdata_d = (req.addr < 8'h10) ? regs_q[req.addr[3:0]] : 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            for (int r = 0; r < 16; r++) begin
                regs_q[r] <= REG_RESET;
            end
            ctrl_q <= REG_RESET;
            mem_q <= REG_RESET;
            caddr_q <= REG_RESET;
            rdata_q <= REG_RESET;
        end else if (I_CLK_EN) begin
            for (int r = 0; r < 16; r++) begin
                regs_q[r] <= regs_d[r];
            end
            ctrl_q <= ctrl_d;
            mem_q <= mem_d;
            caddr_q <= caddr_d;
            rdata_q <= rdata_d;
        end
    end

    // Per-core engine: steps one coefficient per calibration clock
    for (genvar c = 0; c < 2; c++) begin : g_core
        logic sel;
        assign sel = ctrl_q[c == 0 ? CTRL_SEL_I_BIT : CTRL_SEL_Q_BIT];

        always_comb begin
            st_d[c] = st_q[c];
            idx_d[c] = idx_q[c];
            unique case (st_q[c])
                CAL_IDLE: begin
                    if (start && sel) begin
                        st_d[c] = CAL_RUN;
                        idx_d[c] = 5'h00;
                    end
                end
                CAL_RUN: begin
                    if (!start) begin
                        st_d[c] = CAL_IDLE;
                    end else if (cal_tick) begin
                        idx_d[c] = 5'(idx_q[c] + 5'h01);
                        if (idx_q[c] == 5'(NUM_COEF - 1)) begin
                            st_d[c] = CAL_DONE;
                        end
                    end
                end
                CAL_DONE: begin
                    if (!start) begin
                        st_d[c] = CAL_IDLE;
                    end
                end
                default: st_d[c] = CAL_IDLE;
            endcase
        end

        always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
            if (I_RESET) begin
                st_q[c] <= CAL_IDLE;
                idx_q[c] <= 5'h00;
            end else if (I_CLK_EN) begin
                st_q[c] <= st_d[c];
                idx_q[c] <= idx_d[c];
            end
        end

        // coefficient storage; calibration writes each step index as its trial code
        always_ff @(posedge I_CORE_CLK) begin
            if (I_CLK_EN) begin
                if (st_q[c] == CAL_RUN && cal_tick) begin
                    coef_mem[c][idx_q[c]] <= CW'(idx_q[c]);
                end else if (coef_wr && sel) begin
                    coef_mem[c][slot] <= req.wdata[CW-1:0];
                end
            end
        end
    end

    assign O_REG_RDATA = rdata_q;
    assign O_CAL_CLK = cal_clk_q;
    assign O_I_CM_CONNECT = I_I_CM_ENABLE;
    assign O_Q_CM_CONNECT = I_Q_CM_ENABLE;
    assign O_TRIM = '{i_fine: regs_q[3][5:0], i_coarse: regs_q[4][5:0],
                      i_cm: regs_q[5][5:0], q_fine: regs_q[6][5:0],
                      q_coarse: regs_q[7][5:0], q_cm: regs_q[8][5:0],
                      ref_trim: regs_q[13][5:0]};

    // chk_done_needs_start
    chk_done_needs_start: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_q[0] == CAL_DONE) |-> $past(start)) else $error("I done without start");
    // chk_run_not_done
    chk_run_not_done: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CLK_EN && st_q[0] == CAL_RUN && start && !cal_tick |=> st_q[0] != CAL_DONE)
        else $error("Done raised early");
    // chk_clock_gated
    chk_clock_gated: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CLK_EN && !ctrl_q[CTRL_CLK_EN_BIT] |=> !cal_clk_q) else $error("Clock not gated");
    // chk_prescale_wrap
    chk_prescale_wrap: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        $changed(cal_clk_q) && $past(ctrl_q[CTRL_CLK_EN_BIT])
        |-> $past(pre_q) == 4'(CAL_PREDIV - 1)) else $error("Bad divide");
    // chk_read_coef
    chk_read_coef: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CLK_EN && req.rd && req.addr == ADDR_COEF_DATA && !mem_q[MEM_RD_EN_BIT]
        |=> rdata_q == 8'h00) else $error("Read without enable");
    // chk_status_read
    chk_status_read: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CLK_EN && req.rd && req.addr == ADDR_CAL_STATUS && st_q[1] == CAL_DONE
        ##1 1'b1 |-> rdata_q[STAT_DONE_Q_BIT] || $past(st_q[1]) != CAL_DONE)
        else $error("Q done missing");
    // chk_start_runs
    chk_start_runs: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CLK_EN && st_q[0] == CAL_IDLE && start && ctrl_q[CTRL_SEL_I_BIT]
        |=> st_q[0] == CAL_RUN) else $error("Start ignored");
    // chk_ref_trim
    chk_ref_trim: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CLK_EN && req.wr && req.addr == ADDR_REF_TRIM |=> O_TRIM.ref_trim == $past(req.wdata[5:0]))
        else $error("Trim not stored");
    cov_cal_done: cover property (@(posedge I_CORE_CLK) st_q[0] == CAL_DONE);
    cov_both_run: cover property (@(posedge I_CORE_CLK) st_q[0] == CAL_RUN && st_q[1] == CAL_RUN);
    cov_coef_wr: cover property (@(posedge I_CORE_CLK) coef_wr);
endmodule // dac_cal_ctrl

// ### include/dac_cal_pkg.sv
/*
 Constants and carrier types for the converter calibration and gain block.
 Assumes a byte-wide register port driven synchronously to the core clock.
*/
package dac_cal_pkg;
    localparam logic [7:0] ADDR_I_FINE_GAIN = 8'h03;
    localparam logic [7:0] ADDR_I_COARSE_GAIN = 8'h04;
    localparam logic [7:0] ADDR_I_CM_RES = 8'h05;
    localparam logic [7:0] ADDR_Q_FINE_GAIN = 8'h06;
    localparam logic [7:0] ADDR_Q_COARSE_GAIN = 8'h07;
    localparam logic [7:0] ADDR_Q_CM_RES = 8'h08;
    localparam logic [7:0] ADDR_REF_TRIM = 8'h0D;
    localparam logic [7:0] ADDR_CAL_CTRL = 8'h0E;
    localparam logic [7:0] ADDR_CAL_STATUS = 8'h0F;
    localparam logic [7:0] ADDR_COEF_ADDR = 8'h10;
    localparam logic [7:0] ADDR_COEF_DATA = 8'h11;
    localparam logic [7:0] ADDR_CAL_MEM_CTRL = 8'h12;
    // Field positions
    localparam int CTRL_CLK_EN_BIT = 3;
    localparam int CTRL_SEL_I_BIT = 4;
    localparam int CTRL_SEL_Q_BIT = 5;
    localparam int STAT_DONE_I_BIT = 6;
    localparam int STAT_DONE_Q_BIT = 7;
    localparam int MEM_UNCAL_Q_BIT = 0;
    localparam int MEM_UNCAL_I_BIT = 1;
    localparam int MEM_RD_EN_BIT = 2;
    localparam int MEM_WR_EN_BIT = 3;
    localparam int MEM_START_BIT = 4;
    // Reset values (none documented; zero chosen)
    localparam logic [7:0] REG_RESET = 8'h00;
    // Timing counts, in converter clock cycles, then coefficient memory layout
    localparam int CAL_PREDIV = 16;
    localparam int CAL_MIN_DIV = 32;
    localparam int CAL_MAX_DIV = 2048;
    localparam int COEF_COUNT = 32;
    localparam int COEF_WIDTH = 6;
    localparam int COEF_FIRST_ADDR = 1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [5:0] i_fine;
        logic [5:0] i_coarse;
        logic [5:0] i_cm;
        logic [5:0] q_fine;
        logic [5:0] q_coarse;
        logic [5:0] q_cm;
        logic [5:0] ref_trim;
    } trim_t;
endpackage

// ### tb/host_port_model.sv
/*
 Host model for the register port: byte writes, reads and the
 calibration and coefficient access sequences.
 Assumes strobes are sampled on the rising edge of clk.
*/
`timescale 1ns/1ns
module host_port_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic rd,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'hFF;
        wdata = 8'hFF;
    end

    // Idle bus shows inverted values, never the last ones
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask

    task automatic calibrate(input logic [7:0] sel, output logic [7:0] mid,
                             output logic [7:0] fin, output logic [7:0] clr);
        put(8'h12, 8'h00);
        // divide by 128, near 2 MHz
        put(8'h0E, 8'h0A);
        put(8'h0E, 8'h0A | sel);
        put(8'h12, 8'h10);
        repeat (10 * 128) @(negedge clk);
        get(8'h0F, mid);
        repeat (40 * 128) @(negedge clk);
        get(8'h0F, fin);
        put(8'h12, 8'h00);
        get(8'h0F, clr);
        put(8'h0E, 8'h00);
    endtask

    task automatic coef_write(input logic [7:0] a, input logic [7:0] d);
        put(8'h12, 8'h08);
        put(8'h10, a);
        put(8'h11, d);
    endtask

    task automatic coef_read(input logic [7:0] a, output logic [7:0] d);
        put(8'h10, a);
        put(8'h12, 8'h04);
        get(8'h11, d);
        put(8'h12, 8'h00);
    endtask
endmodule // host_port_model

// ### tb/test_dual_dac_calibration_and_gain.sv
/*
 Self-checking bench for the calibration and gain block.
 Assumes one converter sample per core clock, or every other one when
 the half-rate tick is asked for.
*/
`timescale 1ns/1ns
module test_dual_dac_calibration_and_gain;
    import dac_cal_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b1;
    logic tick_half = 1'b0;
    logic i_cm_en = 1'b0;
    logic q_cm_en = 1'b0;
    logic wr, rd, cal_clk, i_conn, q_conn;
    logic [7:0] addr, wdata, rdata;
    trim_t trim;
    int n_fail = 0;
    int cmp_count = 0;

    always #2 clk = ~clk;

    // Half-rate ticks prove the divider counts samples, not core clocks
    always @(negedge clk) tick <= tick_half ? ~tick : 1'b1;

    dac_cal_ctrl i_dac_cal_ctrl (.I_CORE_CLK(clk), .I_RESET(rst), .I_CLK_EN(1'b1),
        .I_DAC_CLK_TICK(tick), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_I_CM_ENABLE(i_cm_en), .I_Q_CM_ENABLE(q_cm_en),
        .O_REG_RDATA(rdata), .O_CAL_CLK(cal_clk), .O_I_CM_CONNECT(i_conn),
        .O_Q_CM_CONNECT(q_conn), .O_TRIM(trim));

    host_port_model i_host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd),
        .addr(addr), .wdata(wdata));

    task automatic check(input string name, input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic test_trim();
        logic [7:0] regs [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0D};
        logic [7:0] vals [7] = '{8'h3F, 8'h20, 8'hC1, 8'h00, 8'h9F, 8'h6A, 8'h1F};
        logic [41:0] e;
        logic [7:0] d;
        e = '0;
        check("cm connect", 48'({i_conn, q_conn}), 48'h0);
        for (int k = 0; k < 7; k++) begin
            i_host.put(regs[k], vals[k]);
            e = {e[35:0], vals[k][5:0]};
        end
        check("trim outputs", 48'(trim), 48'(e));
        for (int k = 0; k < 7; k++) begin
            i_host.get(regs[k], d);
            check("trim readback", 48'(d), 48'(vals[k]));
        end
        @(negedge clk);
        i_cm_en = 1'b1;
        repeat (2) @(negedge clk);
        check("cm connect on", 48'({i_conn, q_conn}), 48'h2);
        q_cm_en = 1'b1;
        @(negedge clk);
        check("cm connect both", 48'({i_conn, q_conn}), 48'h3);
    endtask

    task automatic test_cal_clock();
        int n, t;
        logic p;
        for (int d = 0; d < 9; d++) begin
            tick_half = (d == 8);
            i_host.put(ADDR_CAL_CTRL, 8'h08 | 8'(d));
            repeat (2) begin
                n = 0;
                p = cal_clk;
                repeat (4200) begin
                    @(negedge clk);
                    n++;
                    if (cal_clk === 1'b1 && p === 1'b0) break;
                    p = cal_clk;
                end
            end
            check("cal clock period", 48'(n), 48'(d == 8 ? 2 * CAL_MIN_DIV :
                d == 7 ? CAL_MAX_DIV : CAL_PREDIV << (d + 1)));
        end
        tick_half = 1'b0;
        i_host.put(ADDR_CAL_CTRL, 8'h00);
        @(negedge clk);
        p = cal_clk;
        t = 0;
        repeat (300) begin
            @(negedge clk);
            if (cal_clk !== p) t++;
        end
        check("cal clock stopped", 48'(t), 48'h0);
    endtask

    task automatic test_calibrate();
        logic [7:0] sels [3] = '{8'h10, 8'h20, 8'h30};
        logic [7:0] mid, fin, clr;
        foreach (sels[k]) begin
            i_host.calibrate(sels[k], mid, fin, clr);
            check("done while busy", 48'(mid & 8'hC0), 48'h0);
            check("done flags", 48'(fin & 8'hC0), 48'(sels[k] << 2));
            check("done cleared", 48'(clr & 8'hC0), 48'h0);
        end
        i_host.put(ADDR_CAL_STATUS, 8'hFF);
        i_host.get(ADDR_CAL_STATUS, mid);
        check("status read only", 48'(mid & 8'hC0), 48'h0);
    endtask

    task automatic test_coef();
        logic [7:0] d;
        i_host.put(ADDR_CAL_CTRL, 8'h20);
        for (int a = 1; a <= 32; a++) i_host.coef_write(8'(a), 8'(a ^ 8'h15) & 8'h3F);
        i_host.put(ADDR_CAL_CTRL, 8'h10);
        for (int a = 1; a <= 32; a++) i_host.coef_write(8'(a), 8'(64 - a));
        i_host.put(ADDR_CAL_MEM_CTRL, 8'h00);
        for (int a = 1; a <= 32; a++) begin
            i_host.coef_read(8'(a), d);
            check("coef core i", 48'(d), 48'(64 - a));
        end
        i_host.put(ADDR_CAL_CTRL, 8'h20);
        for (int a = 1; a <= 32; a++) begin
            i_host.coef_read(8'(a), d);
            check("coef core q", 48'(d), 48'(8'(a ^ 8'h15) & 8'h3F));
        end
        i_host.coef_read(8'h00, d);
        check("coef addr zero", 48'(d), 48'h0);
        i_host.coef_read(8'h21, d);
        check("coef addr high", 48'(d), 48'h0);
        i_host.put(ADDR_COEF_ADDR, 8'h01);
        i_host.get(ADDR_COEF_DATA, d);
        check("coef no enable", 48'(d), 48'h0);
        i_host.get(8'h40, d);
        check("unmapped read", 48'(d), 48'h0);
    endtask

    initial begin
        #250000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        test_trim();
        test_cal_clock();
        test_calibrate();
        test_coef();
        summarize();
    end
endmodule // test_dual_dac_calibration_and_gain
